// >>> verilog/fsp_sequencer.sv
// Flash self-programming sequencer: arm register, page buffer, erase/write timer.
// Assumes an AXI4-Lite master, a CPU that stalls on cpu_stall, fuse pins static.
//
// Contract
// RULE1: Store instruction is accepted regardless of where the CPU is executing.
// RULE2: Erase happens only when store follows erase arm within four cycles.
// RULE3: Erase uses Z bits 12..6 as page; other Z bits and data ignored.
// RULE4: CPU stalls for the whole page erase.
// RULE5: Load arm plus store within four cycles writes data word to buffer.
// RULE6: Buffer slot chosen by Z bits 5..1 during load.
// RULE7: Buffer clears after page write, on buffer-clear command, and on reset.
// RULE8: Software loads each slot at most once between clears.
// RULE9: EEPROM write starting during loading discards loaded buffer contents.
// RULE10: Write arm plus store within four cycles programs page from buffer.
// RULE11: CPU stalls for the whole page write.
// RULE12: Buffer loads in any order; erase and write pages addressed independently.
// RULE13: Software disables interrupts before arming to keep the window atomic.
// RULE14: EEPROM write busy blocks all programming and fuse or lock reads.
// RULE15: Software polls EEPROM busy before writing the control register.
// RULE16: Z 0x0001 with lock-read armed, load within three returns lock bits.
// RULE17: Lock-read and enable clear on read, three cycles no load, four no store.
// RULE18: Lock-read load returns fuse low, high, extended for Z 0, 3, 2.
// RULE19: Fuse and lock read back zero when programmed, one when not.
// RULE20: Reset during a flash write lets that write finish.
// RULE21: Erase or write lasts between 3.2 ms and 3.4 ms.
// RULE22: Byte reads of program memory use Z bit 0 for low or high byte.
// RULE23: Store enable clears on store or four idle cycles; stays set through program.
// RULE24: Section busy bit always reads zero.
// RULE25: Ready interrupt when enable clear, irq and global enables set, no EEPROM write.
// RULE26: Command decoded from low five bits; unsupported combinations ignored.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
module fsp_sequencer #(
   parameter int PROG_CYC = fsp_pkg::FSP_PROG_CYC,
   parameter int WORDS = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic eeprom_write_busy,
   input wire logic global_irq_enable,
   input wire logic [7:0] fuse_low_byte,
   input wire logic [7:0] fuse_high_byte,
   input wire logic [7:0] extended_fuse_byte,
   input wire logic [7:0] lock_bit_set,
   output logic cpu_stall,
   output logic ready_irq,
   output logic flash_we,
   output logic flash_erase,
   output logic [6:0] flash_page,
   output logic [15:0] flash_wdata,
   output logic [4:0] flash_word
);
   // ==========================================
   // State record
   typedef struct packed {
      fsp_pkg::fsp_state_t st;
      logic [4:0] ctrl;
      logic irq_en;
      logic [2:0] win;
      logic [15:0] z;
      logic [15:0] data;
      logic [7:0] rbyte;
      fsp_pkg::fsp_op_t op;
      logic [6:0] page;
      logic [21:0] tmr;
      logic [4:0] idx;
      logic wpend;
      logic rst_fin;
      logic awf;
      logic wf;
      logic [7:0] awa;
      logic [31:0] wd;
      logic bv;
      logic rv;
      logic [31:0] rd;
      logic ee_s1;
      logic ee_s2;
      logic ee_prev;
      logic loading;
   } fsp_reg_t;

   fsp_reg_t q, d;
   logic [15:0] buf_mem [WORDS];
   logic [WORDS-1:0] buf_vld_q;
   logic buf_we;
   logic buf_clr;
   logic [15:0] rd_mux;
   logic wr_go;

   assign wr_go = q.awf && q.wf && !q.bv;

   // Register readback mux
   always_comb
   begin
      rd_mux = 16'h0000;
      case (q.awa)
         default: rd_mux = 16'h0000;
      endcase
   end

   // ==========================================
   // Next state
   always_comb
   begin
      logic [4:0] cmd;
      logic ee_start;
      cmd = 5'h00;
      ee_start = 1'b0;
      d = q;
      buf_we = 1'b0;
      buf_clr = 1'b0;
      d.ee_s1 = eeprom_write_busy;
      d.ee_s2 = q.ee_s1;
      d.ee_prev = q.ee_s2;
      ee_start = q.ee_s2 && !q.ee_prev;
      // Write channel capture, either order
      if (s_axi_awvalid && !q.awf)
      begin
         d.awf = 1'b1;
         d.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.wf)
      begin
         d.wf = 1'b1;
         d.wd = s_axi_wdata;
      end
      if (q.bv && s_axi_bready)
         d.bv = 1'b0;
      if (q.rv && s_axi_rready)
         d.rv = 1'b0;
      // Arm window counts down while armed
      if (q.st == fsp_pkg::FSP_ARMED)
      begin
         if (q.win == 3'h0)
         begin
            d.st = fsp_pkg::FSP_IDLE; // [RULE17] [RULE23]
            d.ctrl = 5'h00;
         end
         else
            d.win = q.win - 3'h1;
         // Lock read lapses one cycle earlier than store
         if (q.ctrl[fsp_pkg::FSP_LOCK_RD_POS] && q.win == 3'h1)
         begin
            d.st = fsp_pkg::FSP_IDLE; // [RULE17]
            d.ctrl = 5'h00;
         end
      end
      // Program timer; enable bit held until done
      if (q.st == fsp_pkg::FSP_PROG)
      begin
         if (q.tmr == 22'(PROG_CYC - 1))
         begin
            d.st = fsp_pkg::FSP_IDLE; // [RULE21] [RULE23]
            d.ctrl = 5'h00;
            d.op = fsp_pkg::FSP_OP_NONE;
            d.rst_fin = 1'b0;
            if (q.op == fsp_pkg::FSP_OP_WRITE)
               buf_clr = 1'b1; // [RULE7]
         end
         else
            d.tmr = q.tmr + 22'h1;
      end
      // EEPROM write starting mid-load drops the buffer
      if (ee_start && q.loading)
      begin
         buf_clr = 1'b1; // [RULE9]
         d.loading = 1'b0;
      end
      if (wr_go)
      begin
         d.awf = 1'b0;
         d.wf = 1'b0;
         d.bv = 1'b1;
         case (q.awa)
            fsp_pkg::FSP_CTRL_OFF:
            begin
               d.irq_en = q.wd[fsp_pkg::FSP_IRQ_EN_POS];
               cmd = q.wd[4:0];
               // EEPROM busy or busy sequencer blocks arming
               if (q.st == fsp_pkg::FSP_IDLE && !q.ee_s2) // [RULE14]
               begin
                  case (cmd) // [RULE26]
                     fsp_pkg::FSP_CMD_LOAD, fsp_pkg::FSP_CMD_ERASE, fsp_pkg::FSP_CMD_WRITE,
                     fsp_pkg::FSP_CMD_LOCK, fsp_pkg::FSP_CMD_CLR:
                     begin
                        d.st = fsp_pkg::FSP_ARMED;
                        d.ctrl = cmd;
                        d.win = 3'(fsp_pkg::FSP_STORE_WIN - 1); // [RULE2]
                     end
                     default: d.ctrl = q.ctrl;
                  endcase
               end
            end
            fsp_pkg::FSP_ZPTR_OFF: d.z = q.wd[15:0];
            fsp_pkg::FSP_DATA_OFF: d.data = q.wd[15:0];
            fsp_pkg::FSP_CMD_OFF:
            begin
               // Store instruction, from any address [RULE1]
               // EEPROM write started after arming still blocks the store [RULE14]
               if (q.wd[1:0] == fsp_pkg::FSP_INS_STORE && q.st == fsp_pkg::FSP_ARMED
                   && !q.ctrl[fsp_pkg::FSP_LOCK_RD_POS] && !q.ee_s2)
               begin
                  d.st = fsp_pkg::FSP_IDLE;
                  d.ctrl = 5'h00; // [RULE23]
                  case (q.ctrl)
                     fsp_pkg::FSP_CMD_LOAD:
                     begin
                        buf_we = 1'b1; // [RULE5]
                        d.loading = 1'b1;
                     end
                     fsp_pkg::FSP_CMD_ERASE, fsp_pkg::FSP_CMD_WRITE:
                     begin
                        d.st = fsp_pkg::FSP_PROG; // [RULE4] [RULE11]
                        d.ctrl = q.ctrl;
                        d.tmr = 22'h0;
                        d.page = q.z[12:6]; // [RULE3] [RULE10] [RULE12]
                        d.op = (q.ctrl == fsp_pkg::FSP_CMD_ERASE) ? fsp_pkg::FSP_OP_ERASE
                                                                 : fsp_pkg::FSP_OP_WRITE;
                        d.loading = 1'b0;
                     end
                     fsp_pkg::FSP_CMD_CLR:
                     begin
                        buf_clr = 1'b1; // [RULE7]
                        d.loading = 1'b0;
                     end
                     default: d.ctrl = 5'h00;
                  endcase
               end
               // Load instruction: fuse/lock when lock read armed, else buffer byte
               if (q.wd[1:0] == fsp_pkg::FSP_INS_LOAD)
               begin
                  if (q.st == fsp_pkg::FSP_ARMED && q.ctrl == fsp_pkg::FSP_CMD_LOCK && !q.ee_s2) // [RULE14]
                  begin
                     d.st = fsp_pkg::FSP_IDLE;
                     d.ctrl = 5'h00; // [RULE17]
                     case (q.z) // [RULE16] [RULE18] [RULE19]
                        fsp_pkg::FSP_Z_LOCK: d.rbyte = lock_bit_set;
                        fsp_pkg::FSP_Z_FUSE_LO: d.rbyte = fuse_low_byte;
                        fsp_pkg::FSP_Z_FUSE_HI: d.rbyte = fuse_high_byte;
                        fsp_pkg::FSP_Z_FUSE_EXT: d.rbyte = extended_fuse_byte;
                        default: d.rbyte = 8'hff;
                     endcase
                  end
                  else
                     d.rbyte = q.z[0] ? buf_mem[q.z[5:1]][15:8] : buf_mem[q.z[5:1]][7:0]; // [RULE22]
               end
            end
            default: d.ctrl = d.ctrl;
         endcase
      end
      // Read channel
      if (s_axi_arvalid && !q.rv)
      begin
         d.rv = 1'b1;
         case (s_axi_araddr)
            fsp_pkg::FSP_CTRL_OFF: d.rd = {24'h0, q.irq_en, 1'b0, 1'b0, q.ctrl}; // [RULE24]
            fsp_pkg::FSP_ZPTR_OFF: d.rd = {16'h0, q.z};
            fsp_pkg::FSP_DATA_OFF: d.rd = {16'h0, q.data};
            fsp_pkg::FSP_RDATA_OFF: d.rd = {24'h0, q.rbyte};
            fsp_pkg::FSP_STAT_OFF: d.rd = {29'h0, q.loading, q.ee_s2, cpu_stall};
            fsp_pkg::FSP_ADDR_OFF: d.rd = {25'h0, q.page};
            default: d.rd = {16'h0, rd_mux};
         endcase
      end
   end

   // ==========================================
   // State register; a reset mid-program lets the program finish
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
         if (q.st == fsp_pkg::FSP_PROG) // [RULE20]
         begin
            q.st <= fsp_pkg::FSP_PROG;
            q.op <= q.op;
            q.page <= q.page;
            q.tmr <= q.tmr;
            q.ctrl <= q.ctrl;
            q.rst_fin <= 1'b1;
         end
      end
      else if (clk_en)
         q <= d;
   end

   // Page buffer; valid bits cleared, contents kept for area
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         buf_vld_q <= '0; // [RULE7]
      else if (clk_en)
      begin
         if (buf_clr)
            buf_vld_q <= '0;
         else if (buf_we)
            buf_vld_q[q.z[5:1]] <= 1'b1; // [RULE8]
      end
   end

   always_ff @(posedge aclk)
   begin
      if (clk_en && buf_we)
         buf_mem[q.z[5:1]] <= q.data; // [RULE6] [RULE12]
   end

   // ==========================================
   // Outputs
   assign s_axi_awready = !q.awf;
   assign s_axi_wready = !q.wf;
   assign s_axi_bvalid = q.bv;
   assign s_axi_bresp = 2'b00;
   assign s_axi_arready = !q.rv;
   assign s_axi_rvalid = q.rv;
   assign s_axi_rdata = q.rd;
   assign s_axi_rresp = 2'b00;
   assign cpu_stall = (q.st == fsp_pkg::FSP_PROG); // [RULE4] [RULE11]
   assign ready_irq = q.irq_en && global_irq_enable && !q.ctrl[fsp_pkg::FSP_STORE_EN_POS]
                      && !q.ee_s2; // [RULE25] [RULE13] [RULE15]
   assign flash_erase = (q.st == fsp_pkg::FSP_PROG) && (q.op == fsp_pkg::FSP_OP_ERASE);
   assign flash_we = (q.st == fsp_pkg::FSP_PROG) && (q.op == fsp_pkg::FSP_OP_WRITE);
   assign flash_page = q.page;
   assign flash_word = q.tmr[4:0];
   assign flash_wdata = buf_vld_q[q.tmr[4:0]] ? buf_mem[q.tmr[4:0]] : 16'hffff;
endmodule
`default_nettype wire

// >>> verilog/fsp_pkg.sv
// Package for the flash self-programming sequencer: register map, fields, timing.
// Assumes one 10 MHz clock and an AXI4-Lite master on the register side.
`default_nettype none
package fsp_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] FSP_CTRL_OFF = 8'h00;
   localparam logic [7:0] FSP_ZPTR_OFF = 8'h04;
   localparam logic [7:0] FSP_DATA_OFF = 8'h08;
   localparam logic [7:0] FSP_CMD_OFF = 8'h0c;
   localparam logic [7:0] FSP_RDATA_OFF = 8'h10;
   localparam logic [7:0] FSP_STAT_OFF = 8'h14;
   localparam logic [7:0] FSP_FUSE_OFF = 8'h18;
   localparam logic [7:0] FSP_ADDR_OFF = 8'h1c;
   // ==========================================
   // Control field positions
   localparam int FSP_STORE_EN_POS = 0;
   localparam int FSP_ERASE_POS = 1;
   localparam int FSP_WRITE_POS = 2;
   localparam int FSP_LOCK_RD_POS = 3;
   localparam int FSP_BUF_CLR_POS = 4;
   localparam int FSP_BUSY_POS = 6;
   localparam int FSP_IRQ_EN_POS = 7;
   // Accepted command codes, low five bits
   localparam logic [4:0] FSP_CMD_LOAD = 5'h01;
   localparam logic [4:0] FSP_CMD_ERASE = 5'h03;
   localparam logic [4:0] FSP_CMD_WRITE = 5'h05;
   localparam logic [4:0] FSP_CMD_LOCK = 5'h09;
   localparam logic [4:0] FSP_CMD_CLR = 5'h11;
   // Instruction codes on the command register
   localparam logic [1:0] FSP_INS_STORE = 2'h1;
   localparam logic [1:0] FSP_INS_LOAD = 2'h2;
   // Z values for fuse and lock reads
   localparam logic [15:0] FSP_Z_FUSE_LO = 16'h0000;
   localparam logic [15:0] FSP_Z_LOCK = 16'h0001;
   localparam logic [15:0] FSP_Z_FUSE_EXT = 16'h0002;
   localparam logic [15:0] FSP_Z_FUSE_HI = 16'h0003;
   // ==========================================
   // Timing
   localparam int FSP_STORE_WIN = 4;
   localparam int FSP_LOAD_WIN = 3;
   localparam int FSP_CLK_KHZ = 10000;
   localparam int FSP_PROG_MIN_US = 3200;
   localparam int FSP_PROG_MAX_US = 3400;
   // Least time rounded up in cycles
   localparam int FSP_PROG_CYC = (FSP_PROG_MIN_US * FSP_CLK_KHZ + 999) / 1000;
   localparam logic [7:0] FSP_RESET_BYTE = 8'h00;
   // ==========================================
   // Types
   typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_PROG} fsp_state_t;
   typedef enum logic [1:0] {FSP_OP_NONE, FSP_OP_ERASE, FSP_OP_WRITE} fsp_op_t;
   typedef struct packed {
      logic [6:0] page;
      logic [4:0] word;
      logic lowbyte;
   } fsp_zaddr_t;
endpackage
`default_nettype wire

// >>> verification/fsp_sequencer_props.sv
// Checker for the flash self-programming sequencer, watching its ports only.
// Assumes one clock domain and a synchronous active-low reset; bound at the foot.
`default_nettype none
module fsp_sequencer_props #(
   parameter int PROG_CYC = fsp_pkg::FSP_PROG_CYC,
   parameter int WORDS = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic eeprom_write_busy,
   input wire logic global_irq_enable,
   input wire logic cpu_stall,
   input wire logic ready_irq,
   input wire logic flash_we,
   input wire logic flash_erase,
   input wire logic [6:0] flash_page
);
   // ==========================================
   // Stall length counter
   // Not cleared by reset: a program run outlives it
   logic [31:0] run_q;
   logic [31:0] run_d;
   always_comb run_d = cpu_stall ? run_q + 32'h1 : 32'h0;
   always_ff @(posedge aclk) run_q <= run_d;

   // ==========================================
   // Properties
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Busy long enough to pass the two-stage synchroniser
   sequence s_ee_held;
      eeprom_write_busy [*4];
   endsequence
   property p_stall_len;
      $fell(cpu_stall) |-> run_q >= PROG_CYC && run_q <= (PROG_CYC * 17) / 16;
   endproperty
   property p_erase_halts;
      flash_erase |-> cpu_stall;
   endproperty
   property p_write_halts;
      flash_we |-> cpu_stall;
   endproperty
   property p_one_op;
      cpu_stall |-> flash_we ^ flash_erase;
   endproperty
   property p_page_held;
      cpu_stall && $past(cpu_stall) && $past(aresetn) |-> $stable(flash_page);
   endproperty
   property p_ee_block;
      s_ee_held |-> !$rose(cpu_stall);
   endproperty
   property p_irq_cause;
      ready_irq |-> global_irq_enable && !cpu_stall;
   endproperty
   property p_irq_ee;
      s_ee_held |-> !ready_irq;
   endproperty
   a_stall_len: assert property (p_stall_len) else $error("program time out of range");
   a_erase_halts: assert property (p_erase_halts) else $error("erase without stall");
   a_write_halts: assert property (p_write_halts) else $error("write without stall");
   a_one_op: assert property (p_one_op) else $error("stall without one program op");
   a_page_held: assert property (p_page_held) else $error("page moved during program");
   a_ee_block: assert property (p_ee_block) else $error("program began while eeprom busy");
   a_irq_cause: assert property (p_irq_cause) else $error("ready irq without cause");
   a_irq_ee: assert property (p_irq_ee) else $error("ready irq during eeprom write");
endmodule

bind fsp_sequencer fsp_sequencer_props #(.PROG_CYC(PROG_CYC), .WORDS(WORDS)) i_fsp_sequencer_props (
   .aclk(aclk),
   .aresetn(aresetn),
   .eeprom_write_busy(eeprom_write_busy),
   .global_irq_enable(global_irq_enable),
   .cpu_stall(cpu_stall),
   .ready_irq(ready_irq),
   .flash_we(flash_we),
   .flash_erase(flash_erase),
   .flash_page(flash_page)
);
`default_nettype wire

// >>> verification/fsp_flash_model.sv
// Flash array model on the program outputs of the sequencer.
// Assumes flash_word sweeps every slot while flash_we is high.
`default_nettype none
module fsp_flash_model (
   input wire logic aclk,
   input wire logic flash_we,
   input wire logic flash_erase,
   input wire logic [6:0] flash_page,
   input wire logic [15:0] flash_wdata,
   input wire logic [4:0] flash_word
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Array and erase counter
   logic [15:0] mem [0:31];
   logic [6:0] page_q;
   logic er_q = 1'b0;
   int erase_count = 0;
   // Last page seen, erase and write must agree
   always @(posedge aclk)
   begin
      er_q <= flash_erase;
      if (flash_erase && !er_q)
         erase_count++;
      if (flash_we || flash_erase)
         page_q <= flash_page;
      if (flash_we)
         mem[flash_word] <= flash_wdata;
   end
endmodule
`default_nettype wire

// >>> verification/tb_fsp_sequencer.sv
// Self-checking bench for the flash sequencer, driven over AXI4-Lite.
// Assumes the bound checker and a flash model on the program outputs.
`default_nettype none
module tb_fsp_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PCYC = 40;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic ee_busy, gie, cpu_stall, ready_irq, flash_we, flash_erase;
   logic [6:0] flash_page;
   logic [15:0] flash_wdata;
   logic [4:0] flash_word;
   int n_mismatch = 0;
   int check_count = 0;
   // Fuse levels, zero bits mean programmed
   logic [7:0] fz [0:3] = '{8'h62, 8'hfc, 8'hf9, 8'hd9};

   fsp_sequencer #(.PROG_CYC(PCYC), .WORDS(32)) i_fsp_sequencer (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .eeprom_write_busy(ee_busy), .global_irq_enable(gie),
      .fuse_low_byte(fz[0]), .lock_bit_set(fz[1]), .extended_fuse_byte(fz[2]), .fuse_high_byte(fz[3]),
      .cpu_stall(cpu_stall), .ready_irq(ready_irq), .flash_we(flash_we), .flash_erase(flash_erase),
      .flash_page(flash_page), .flash_wdata(flash_wdata), .flash_word(flash_word));
   fsp_flash_model i_fsp_flash_model (.aclk(aclk), .flash_we(flash_we), .flash_erase(flash_erase),
      .flash_page(flash_page), .flash_wdata(flash_wdata), .flash_word(flash_word));

   // ==========================================
   // Bus and compare tasks, entered just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      if (n >= 50) n_mismatch++;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask
   // Arm and trigger back to back; trigger lands on the third window cycle, the last one for a lock read
   task automatic arm(input logic [4:0] cmd, input logic [15:0] z, input logic [1:0] ins);
      wr(fsp_pkg::FSP_ZPTR_OFF, {16'h0, z});
      wr(fsp_pkg::FSP_CTRL_OFF, {27'h0, cmd});
      wr(fsp_pkg::FSP_CMD_OFF, {30'h0, ins});
   endtask
   task automatic settle;
      int n;
      n = 0;
      while (cpu_stall !== 1'b0 && n < 4 * PCYC)
      begin
         @(posedge aclk);
         n++;
      end
      // A stall that never ends is a failure, not a silent pass
      if (n >= 4 * PCYC) n_mismatch++;
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================
   // Clock and watchdog
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial
   begin
      #(100 * 20000);
      n_mismatch++;
      results;
   end

   // ==========================================
   // Test sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, ee_busy, aresetn} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      gie = 1'b1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(fsp_pkg::FSP_CTRL_OFF, 32'h0, "control at reset");
      rchk(8'h20, 32'h0, "unmapped read");
      chk("irq idle", 32'h0, {31'h0, ready_irq});
      // Loads out of order, then a byte read of slot 3
      wr(fsp_pkg::FSP_DATA_OFF, 32'ha55a);
      arm(fsp_pkg::FSP_CMD_LOAD, 16'h0006, fsp_pkg::FSP_INS_STORE);
      wr(fsp_pkg::FSP_DATA_OFF, 32'h1234);
      arm(fsp_pkg::FSP_CMD_LOAD, 16'h0002, fsp_pkg::FSP_INS_STORE);
      wr(fsp_pkg::FSP_ZPTR_OFF, 32'h0007);
      wr(fsp_pkg::FSP_CMD_OFF, {30'h0, fsp_pkg::FSP_INS_LOAD});
      rchk(fsp_pkg::FSP_RDATA_OFF, 32'ha5, "byte read");
      // Erase with stray Z bits and stray data
      arm(fsp_pkg::FSP_CMD_ERASE, 16'he57f, fsp_pkg::FSP_INS_STORE);
      rd(fsp_pkg::FSP_CTRL_OFF, v);
      chk("enable held", 32'h1, {31'h0, v[0]});
      chk("erase stall", 32'h1, {31'h0, cpu_stall & flash_erase});
      chk("erase page", 32'h15, {25'h0, flash_page});
      settle;
      chk("erase count", 32'h1, i_fsp_flash_model.erase_count);
      // Page write from buffer, then again on the cleared buffer
      arm(fsp_pkg::FSP_CMD_WRITE, 16'h0540, fsp_pkg::FSP_INS_STORE);
      settle;
      chk("slot 3", 32'ha55a, {16'h0, i_fsp_flash_model.mem[3]});
      chk("slot 1", 32'h1234, {16'h0, i_fsp_flash_model.mem[1]});
      chk("slot 0", 32'hffff, {16'h0, i_fsp_flash_model.mem[0]});
      chk("write page", 32'h15, {25'h0, i_fsp_flash_model.page_q});
      arm(fsp_pkg::FSP_CMD_WRITE, 16'h0540, fsp_pkg::FSP_INS_STORE);
      settle;
      chk("cleared slot 3", 32'hffff, {16'h0, i_fsp_flash_model.mem[3]});
      // Clear command drops slot 4, slot 6 loaded after it survives
      wr(fsp_pkg::FSP_DATA_OFF, 32'hbeef);
      arm(fsp_pkg::FSP_CMD_LOAD, 16'h0008, fsp_pkg::FSP_INS_STORE);
      arm(fsp_pkg::FSP_CMD_CLR, 16'h0000, fsp_pkg::FSP_INS_STORE);
      wr(fsp_pkg::FSP_DATA_OFF, 32'hcafe);
      arm(fsp_pkg::FSP_CMD_LOAD, 16'h000c, fsp_pkg::FSP_INS_STORE);
      arm(fsp_pkg::FSP_CMD_WRITE, 16'h0540, fsp_pkg::FSP_INS_STORE);
      settle;
      chk("clr slot 4", 32'hffff, {16'h0, i_fsp_flash_model.mem[4]});
      chk("slot 6", 32'hcafe, {16'h0, i_fsp_flash_model.mem[6]});
      // Eeprom write mid-load blocks erase and discards the buffer
      wr(fsp_pkg::FSP_DATA_OFF, 32'h7777);
      arm(fsp_pkg::FSP_CMD_LOAD, 16'h0004, fsp_pkg::FSP_INS_STORE);
      ee_busy <= 1'b1;
      repeat (4) @(posedge aclk);
      arm(fsp_pkg::FSP_CMD_ERASE, 16'h0540, fsp_pkg::FSP_INS_STORE);
      chk("erase blocked", 32'h0, {31'h0, cpu_stall});
      ee_busy <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(fsp_pkg::FSP_STAT_OFF, v);
      chk("eeprom idle", 32'h0, {31'h0, v[1]});
      arm(fsp_pkg::FSP_CMD_WRITE, 16'h0540, fsp_pkg::FSP_INS_STORE);
      settle;
      chk("lost slot 2", 32'hffff, {16'h0, i_fsp_flash_model.mem[2]});
      // Fuse and lock reads for Z values 0 to 3
      for (int i = 0; i < 4; i++)
      begin
         arm(fsp_pkg::FSP_CMD_LOCK, 16'(i), fsp_pkg::FSP_INS_LOAD);
         rchk(fsp_pkg::FSP_RDATA_OFF, {24'h0, fz[i]}, "fuse byte");
      end
      // Arm lapses with no instruction, bad code ignored
      wr(fsp_pkg::FSP_CTRL_OFF, {27'h0, fsp_pkg::FSP_CMD_LOCK});
      repeat (8) @(posedge aclk);
      rchk(fsp_pkg::FSP_CTRL_OFF, 32'h0, "lapsed arm");
      wr(fsp_pkg::FSP_CTRL_OFF, 32'h07);
      rchk(fsp_pkg::FSP_CTRL_OFF, 32'h0, "bad code");
      // Ready interrupt follows enables
      wr(fsp_pkg::FSP_CTRL_OFF, 32'h81);
      repeat (8) @(posedge aclk);
      chk("irq on", 32'h1, {31'h0, ready_irq});
      gie <= 1'b0;
      @(posedge aclk);
      chk("irq masked", 32'h0, {31'h0, ready_irq});
      // Reset during a page write lets it finish
      arm(fsp_pkg::FSP_CMD_WRITE, 16'h0540, fsp_pkg::FSP_INS_STORE);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("stall past reset", 32'h1, {31'h0, cpu_stall});
      settle;
      results;
   end
endmodule
`default_nettype wire
